//--- design/scl_pkg.sv
// Constants, types and decoders shared by the serial flash configuration loader.
// Assumes a 125 MHz system clock and a single AHB-Lite master.
package scl_pkg;

   localparam int CLK_NS = 8;
   localparam int CLEAR_NS = 1000;
   localparam int CLEAR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] CLEAR_LAST = 8'(CLEAR_CYC - 1);
   localparam logic [6:0] HALF_BASE = 7'h04;

   localparam logic [2:0] MODE_SPI = 3'h1;
   localparam logic [2:0] VS_FAST = 3'h7;
   localparam logic [2:0] VS_READ = 3'h5;
   localparam logic [2:0] VS_ARRAY = 3'h6;
   localparam logic [7:0] CMD_FAST = 8'h0B;
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_ARRAY = 8'hE8;
   localparam logic [2:0] DUMMY_FAST = 3'h1;
   localparam logic [2:0] DUMMY_READ = 3'h0;
   localparam logic [2:0] DUMMY_ARRAY = 3'h4;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_ADDR = 8'h08;
   localparam logic [7:0] OFS_LEN = 8'h0C;
   localparam logic [7:0] OFS_DATA = 8'h10;
   localparam logic [7:0] OFS_WORDS = 8'h14;

   localparam int CTRL_RESTART_BIT = 0;
   localparam int CTRL_RATE_LSB = 4;
   localparam int CTRL_SEL_BIT = 8;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_VS_LSB = 8;
   localparam int ST_MODE_LSB = 12;
   localparam int ST_STRAP_BIT = 16;
   localparam int ST_DONEPIN_BIT = 17;

   localparam logic [3:0] RATE_RST = 4'h0;
   localparam logic SEL_RST = 1'b1;
   localparam logic [23:0] ADDR_RST = 24'h000000;
   localparam logic [15:0] LEN_RST = 16'h0004;

   typedef enum logic [5:0] {
      ST_CLEAR = 6'h01,
      ST_WAIT = 6'h02,
      ST_SEND = 6'h04,
      ST_RECV = 6'h08,
      ST_DONE = 6'h10,
      ST_FAIL = 6'h20
   } scl_state_t;

   typedef struct packed {
      logic ok;
      logic [7:0] cmd;
      logic [2:0] dummy;
   } scl_variant_t;

   function automatic scl_variant_t scl_decode(input logic [2:0] vs);
      scl_variant_t v;
      v = '{ok: 1'b0, cmd: 8'h00, dummy: 3'h0};
      if (vs == VS_FAST) begin
         v = '{ok: 1'b1, cmd: CMD_FAST, dummy: DUMMY_FAST};
      end else if (vs == VS_READ) begin
         v = '{ok: 1'b1, cmd: CMD_READ, dummy: DUMMY_READ};
      end else if (vs == VS_ARRAY) begin
         v = '{ok: 1'b1, cmd: CMD_ARRAY, dummy: DUMMY_ARRAY};
      end
      return v;
   endfunction

   function automatic logic [6:0] scl_send_len(input logic [2:0] dummy);
      return 7'h20 + {1'b0, dummy, 3'h0};
   endfunction

endpackage

//--- design/scl_clk_if.sv
// Carrier between the loader and its configuration clock divider.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface scl_clk_if;
   logic run;
   logic [3:0] rate;
   logic level;
   logic rise;
   logic fall;
   modport gen (input run, input rate, output level, output rise, output fall);
   modport user (output run, output rate, input level, input rise, input fall);
endinterface

//--- design/scl_sync.sv
// Two flip-flop synchroniser for a bundle of pin inputs.
// Assumes the inputs are quasi-static or sampled far from their edges.
`timescale 1ns/1ps
module scl_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } scl_sync_t;

   scl_sync_t st_r;
   scl_sync_t st_nxt;

   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule

//--- design/scl_clkgen.sv
// Divider that makes the configuration clock and its edge ticks.
// Assumes run is held for whole transfers; half period is 4*(rate+1) cycles.
`timescale 1ns/1ps
module scl_clkgen
   import scl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Divider control and ticks
   scl_clk_if.gen cif
);
   typedef struct packed {
      logic [6:0] cnt;
      logic level;
   } scl_cg_t;

   scl_cg_t st_r;
   scl_cg_t st_nxt;
   logic [6:0] last;
   logic wrap;

   assign last = 7'({3'h0, cif.rate} * HALF_BASE + HALF_BASE - 7'h01);
   assign wrap = cif.run && (st_r.cnt == last);

   always_comb begin
      st_nxt = st_r;
      if (!cif.run) begin
         st_nxt = '0;
      end else if (wrap) begin
         st_nxt.cnt = 7'h00;
         st_nxt.level = ~st_r.level;
      end else begin
         st_nxt.cnt = st_r.cnt + 7'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cif.level = st_r.level;
   assign cif.rise = wrap && !st_r.level;
   assign cif.fall = wrap && st_r.level;
endmodule

//--- design/scl_top.sv
// Serial flash configuration loader with an AHB-Lite register port.
// Assumes strap and flash pins are asynchronous and pass through synchronisers.
`timescale 1ns/1ps
module scl_top
   import scl_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic NRST,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Strap pins
   input wire logic [2:0] MODE_PINS,
   input wire logic [2:0] VARIANT_SELECT_PINS,
   input wire logic PULLUP_DISABLE_STRAP,
   // Open-drain indicators
   input wire logic INIT_I,
   output logic INIT_O,
   output logic INIT_OE,
   input wire logic DONE_I,
   output logic DONE_O,
   output logic DONE_OE,
   // Flash link
   output logic CONFIG_CLOCK_OUT,
   output logic FLASH_SELECT_N,
   output logic FLASH_MOSI,
   input wire logic FLASH_DIN,
   // Chain and user pins
   output logic CHAIN_OUT,
   output logic CHAIN_OE,
   output logic PULLUP_ENABLE,
   output logic USER_IO_RELEASE
);
   typedef struct packed {
      scl_state_t state;
      logic [7:0] clr_cnt;
      logic [2:0] mode;
      logic [2:0] vs;
      logic strap;
      logic [55:0] tx;
      logic [6:0] bits;
      logic [6:0] send_len;
      logic mosi;
      logic [31:0] rx;
      logic [4:0] rx_bits;
      logic [15:0] words;
      logic [31:0] data;
      logic chain;
      logic [3:0] rate;
      logic usel;
      logic [23:0] addr;
      logic [15:0] len;
      logic a_wr;
      logic [7:0] a_addr;
      logic [31:0] rdata;
   } scl_main_t;

   localparam scl_main_t ST_RST = '{state: ST_CLEAR, rate: RATE_RST, usel: SEL_RST,
      addr: ADDR_RST, len: LEN_RST, default: '0};

   scl_main_t st_r;
   scl_main_t st_nxt;
   logic [9:0] pins_s;
   logic [2:0] mode_s;
   logic [2:0] vs_s;
   logic strap_s;
   logic din_s;
   logic init_s;
   logic done_s;
   scl_variant_t var_s;
   logic a_take;
   logic loading;
   logic [31:0] status;

   scl_clk_if cif ();

   scl_sync #(.W(10)) u_sync (
      .clk(CLOCK),
      .rst_n(NRST),
      .d({MODE_PINS, VARIANT_SELECT_PINS, PULLUP_DISABLE_STRAP, FLASH_DIN, INIT_I, DONE_I}),
      .q(pins_s)
   );

   scl_clkgen u_clkgen (
      .clk(CLOCK),
      .rst_n(NRST),
      .cif(cif.gen)
   );

   assign {mode_s, vs_s, strap_s, din_s, init_s, done_s} = pins_s;
   assign var_s = scl_decode(vs_s);
   assign a_take = HSEL && HREADY && HTRANS[1] && (HSIZE == 3'h2);
   assign loading = (st_r.state == ST_SEND) || (st_r.state == ST_RECV);
   assign cif.run = loading;
   assign cif.rate = st_r.rate;

   always_comb begin
      status = 32'h00000000;
      status[ST_STATE_LSB +: 6] = st_r.state;
      status[ST_VS_LSB +: 3] = st_r.vs;
      status[ST_MODE_LSB +: 3] = st_r.mode;
      status[ST_STRAP_BIT] = st_r.strap;
      status[ST_DONEPIN_BIT] = done_s;
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.strap = strap_s;
      st_nxt.a_wr = 1'b0;
      // Address phase: latch the write target, or fetch read data now.
      if (a_take) begin
         st_nxt.a_wr = HWRITE;
         st_nxt.a_addr = HADDR[7:0];
         if (HADDR[7:0] == OFS_CTRL) begin
            st_nxt.rdata = {23'h0, st_r.usel, st_r.rate, 4'h0};
         end else if (HADDR[7:0] == OFS_STATUS) begin
            st_nxt.rdata = status;
         end else if (HADDR[7:0] == OFS_ADDR) begin
            st_nxt.rdata = {8'h00, st_r.addr};
         end else if (HADDR[7:0] == OFS_LEN) begin
            st_nxt.rdata = {16'h0000, st_r.len};
         end else if (HADDR[7:0] == OFS_DATA) begin
            st_nxt.rdata = st_r.data;
         end else if (HADDR[7:0] == OFS_WORDS) begin
            st_nxt.rdata = {16'h0000, st_r.words};
         end else begin
            st_nxt.rdata = 32'h00000000;
         end
      end
      case (st_r.state)
         ST_CLEAR: begin
            st_nxt.clr_cnt = st_r.clr_cnt + 8'h01;
            if (st_r.clr_cnt == CLEAR_LAST) begin
               st_nxt.state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (init_s) begin
               st_nxt.mode = mode_s;
               st_nxt.vs = vs_s;
               st_nxt.tx = {var_s.cmd[6:0], st_r.addr, 25'h0};
               st_nxt.mosi = var_s.cmd[7];
               st_nxt.send_len = scl_send_len(var_s.dummy);
               st_nxt.bits = 7'h00;
               st_nxt.words = 16'h0000;
               st_nxt.rx_bits = 5'h00;
               if ((mode_s == MODE_SPI) && var_s.ok) begin
                  st_nxt.state = ST_SEND;
               end else begin
                  st_nxt.state = ST_FAIL;
               end
            end
         end
         ST_SEND: begin
            if (cif.fall) begin
               st_nxt.mosi = st_r.tx[55];
               st_nxt.tx = {st_r.tx[54:0], 1'b0};
               st_nxt.bits = st_r.bits + 7'h01;
               if (st_r.bits == st_r.send_len - 7'h01) begin
                  st_nxt.state = ST_RECV;
                  st_nxt.mosi = 1'b0;
               end
            end
         end
         ST_RECV: begin
            if (cif.fall) begin
               st_nxt.rx = {st_r.rx[30:0], din_s};
               st_nxt.chain = din_s;
               st_nxt.rx_bits = st_r.rx_bits + 5'h01;
               if (st_r.rx_bits == 5'h1F) begin
                  st_nxt.data = {st_r.rx[30:0], din_s};
                  st_nxt.words = st_r.words + 16'h0001;
                  if (st_r.words + 16'h0001 == st_r.len) begin
                     st_nxt.state = ST_DONE;
                  end
               end
            end
         end
         default: begin
         end
      endcase
      // Data phase: apply writes; restart reruns the whole load.
      if (st_r.a_wr) begin
         if (st_r.a_addr == OFS_CTRL) begin
            st_nxt.rate = HWDATA[CTRL_RATE_LSB +: 4];
            st_nxt.usel = HWDATA[CTRL_SEL_BIT];
            if (HWDATA[CTRL_RESTART_BIT]) begin
               st_nxt.state = ST_CLEAR;
               st_nxt.clr_cnt = 8'h00;
               st_nxt.mosi = 1'b0;
            end
         end else if (st_r.a_addr == OFS_ADDR) begin
            st_nxt.addr = HWDATA[23:0];
         end else if (st_r.a_addr == OFS_LEN) begin
            st_nxt.len = HWDATA[15:0];
         end
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign HRDATA = st_r.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign INIT_O = 1'b0;
   assign INIT_OE = (st_r.state == ST_CLEAR);
   assign DONE_O = 1'b0;
   assign DONE_OE = (st_r.state != ST_DONE);
   assign CONFIG_CLOCK_OUT = cif.level;
   assign FLASH_SELECT_N = loading ? 1'b0 : st_r.usel;
   assign FLASH_MOSI = st_r.mosi;
   assign CHAIN_OUT = st_r.chain;
   assign CHAIN_OE = (st_r.state != ST_DONE);
   assign PULLUP_ENABLE = (st_r.state != ST_DONE) && !st_r.strap;
   assign USER_IO_RELEASE = (st_r.state == ST_DONE);

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!NRST);

   sequence seq_enter_send;
      (st_r.state == ST_WAIT) && init_s && (mode_s == MODE_SPI) && var_s.ok;
   endsequence

   sequence seq_recv_fall;
      (st_r.state == ST_RECV) && cif.fall;
   endsequence

   chk_straps_taken: assert property (seq_enter_send |=>
      (st_r.vs == $past(vs_s)) && (st_r.mode == MODE_SPI) && (st_r.state == ST_SEND))
      else $error("Straps not captured at init release.");
   chk_bad_mode: assert property (((st_r.state == ST_WAIT) && init_s &&
      (mode_s != MODE_SPI)) |=> (st_r.state == ST_FAIL))
      else $error("Wrong mode did not fail.");
   chk_first_cmd: assert property (seq_enter_send |=>
      (FLASH_MOSI == $past(var_s.cmd[7])) && (st_r.tx[55:49] == $past(var_s.cmd[6:0])))
      else $error("Read command not loaded.");
   chk_send_length: assert property (seq_enter_send |=>
      (st_r.send_len == 7'h20 + {1'b0, $past(var_s.dummy), 3'h0}))
      else $error("Dummy byte count wrong.");
   chk_init_clear: assert property ((st_r.state == ST_CLEAR) |->
      (INIT_OE && !INIT_O && !USER_IO_RELEASE))
      else $error("Init not held low while clearing.");
   chk_done_low: assert property ((st_r.state != ST_DONE) |-> (DONE_OE && CHAIN_OE))
      else $error("Done released or chain undriven too early.");
   chk_select_held: assert property (loading |-> !FLASH_SELECT_N)
      else $error("Flash select dropped during load.");
   chk_mosi_stable: assert property (((st_r.state == ST_SEND) && !cif.fall && !st_r.a_wr) |=>
      $stable(FLASH_MOSI))
      else $error("Command bit changed away from falling edge.");
   chk_capture_bit: assert property (seq_recv_fall |=>
      (st_r.rx[0] == $past(din_s)) && (CHAIN_OUT == $past(din_s)))
      else $error("Stream bit not captured or forwarded.");
   chk_clock_rise: assert property ((cif.rise && !st_r.a_wr) |=>
      CONFIG_CLOCK_OUT ##1 CONFIG_CLOCK_OUT)
      else $error("Configuration clock did not rise.");
   chk_release_pins: assert property ((st_r.state == ST_DONE) |->
      (USER_IO_RELEASE && !DONE_OE && !PULLUP_ENABLE && (FLASH_SELECT_N == st_r.usel)))
      else $error("Pins not released after done.");
   chk_pullup_strap: assert property ((st_r.state != ST_DONE) |->
      (PULLUP_ENABLE == !$past(strap_s)))
      else $error("Pull-up control does not follow strap.");

   // Each valid variant code loads its own command and header length.
   chk_fast_header: assert property (((st_r.state == ST_WAIT) && init_s &&
      (mode_s == MODE_SPI) && (vs_s == VS_FAST)) |=> (st_r.send_len == 7'h28) &&
      (FLASH_MOSI == CMD_FAST[7]) && (st_r.tx[55:49] == CMD_FAST[6:0]))
      else $error("Fast read header wrong.");
   chk_read_header: assert property (((st_r.state == ST_WAIT) && init_s &&
      (mode_s == MODE_SPI) && (vs_s == VS_READ)) |=> (st_r.send_len == 7'h20) &&
      (FLASH_MOSI == CMD_READ[7]) && (st_r.tx[55:49] == CMD_READ[6:0]))
      else $error("Plain read header wrong.");
   chk_array_header: assert property (((st_r.state == ST_WAIT) && init_s &&
      (mode_s == MODE_SPI) && (vs_s == VS_ARRAY)) |=> (st_r.send_len == 7'h40) &&
      (FLASH_MOSI == CMD_ARRAY[7]) && (st_r.tx[55:49] == CMD_ARRAY[6:0]))
      else $error("Array read header wrong.");
   chk_reserved_code: assert property (((st_r.state == ST_WAIT) && init_s &&
      (mode_s == MODE_SPI) && (vs_s != VS_FAST) && (vs_s != VS_READ) &&
      (vs_s != VS_ARRAY)) |=> (st_r.state == ST_FAIL))
      else $error("Reserved variant code did not fail.");
   // The flash clock rests low whenever no load is running.
   chk_clock_idle: assert property (!loading |=> !CONFIG_CLOCK_OUT)
      else $error("Configuration clock ran outside a load.");
   // After the header only zeros go out while the stream comes in.
   chk_mosi_quiet: assert property ((st_r.state == ST_RECV) |-> !FLASH_MOSI)
      else $error("Serial output not quiet while receiving.");
endmodule

//--- tb/scl_flash_model.sv
// Behavioural serial flash that streams bytes after a read header.
// Assumes input sampled on rising clock, output changed on falling clock.
`timescale 1ns/1ps
module scl_flash_model (
   // Flash pins
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic hold_n,
   output logic miso
);
   int nbit = 0;
   int hdr;
   int k;
   logic [7:0] cmd = 8'h00;
   logic [23:0] addr = 24'h000000;
   logic [23:0] a;
   logic [7:0] b;
   initial miso = 1'b0;
   // Writes are not modelled, so the protect input needs no handling here.
   // Header length follows the dummy byte count of the command.
   always_comb hdr = (cmd == 8'h0B) ? 40 : ((cmd == 8'hE8) ? 64 : 32);
   always @(negedge cs_n) nbit = 0;
   // Command then address are shifted in on the rising clock while hold is high.
   always @(posedge sck) begin
      if (!cs_n && hold_n) begin
         if (nbit < 8) cmd = {cmd[6:0], mosi};
         else if (nbit < 32) addr = {addr[22:0], mosi};
         nbit = nbit + 1;
      end
   end
   // Data bytes stream MSB first from the start address; the line churns otherwise.
   always @(negedge sck) begin
      if (!cs_n && nbit >= hdr) begin
         k = nbit - hdr;
         a = addr + 24'(k / 8);
         b = a[7:0] ^ 8'h5A;
         miso = b[7 - (k % 8)];
      end else begin
         miso = ~miso;
      end
   end
   always @(posedge cs_n) miso = ~miso;
endmodule

//--- tb/test_spi_flash_config_master.sv
// Self-checking bench for the serial flash configuration loader.
// Assumes the flash model on the link and the bench as the AHB-Lite master.
`timescale 1ns/1ps
module test_spi_flash_config_master;
   import scl_pkg::*;
   localparam int LIM = 20000;
   logic CLOCK = 1'b0;
   logic NRST = 1'b0;
   logic HSEL = 1'b0;
   logic [31:0] HADDR = 32'h00000000;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [2:0] HSIZE = 3'h2;
   logic [31:0] HWDATA = 32'h00000000;
   logic [31:0] HRDATA;
   logic HREADYOUT, HRESP, INIT_O, INIT_OE, DONE_O, DONE_OE;
   logic CONFIG_CLOCK_OUT, FLASH_SELECT_N, FLASH_MOSI, FLASH_DIN;
   logic CHAIN_OUT, CHAIN_OE, PULLUP_ENABLE, USER_IO_RELEASE;
   logic [2:0] MODE_PINS = MODE_SPI;
   logic [2:0] VARIANT_SELECT_PINS = VS_FAST;
   logic PULLUP_DISABLE_STRAP = 1'b0;
   logic init_hold = 1'b0;
   logic hold_n = 1'b1;
   wire INIT_I = !(INIT_OE || init_hold);
   wire DONE_I = !DONE_OE;
   int fails = 0;
   int num_checks = 0;
   int sel_rises = 0;

   always #4 CLOCK = ~CLOCK;
   always @(posedge FLASH_SELECT_N) sel_rises++;

   scl_top dut (.CLOCK(CLOCK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MODE_PINS(MODE_PINS),
      .VARIANT_SELECT_PINS(VARIANT_SELECT_PINS), .PULLUP_DISABLE_STRAP(PULLUP_DISABLE_STRAP),
      .INIT_I(INIT_I), .INIT_O(INIT_O), .INIT_OE(INIT_OE), .DONE_I(DONE_I), .DONE_O(DONE_O),
      .DONE_OE(DONE_OE), .CONFIG_CLOCK_OUT(CONFIG_CLOCK_OUT), .FLASH_SELECT_N(FLASH_SELECT_N),
      .FLASH_MOSI(FLASH_MOSI), .FLASH_DIN(FLASH_DIN), .CHAIN_OUT(CHAIN_OUT),
      .CHAIN_OE(CHAIN_OE), .PULLUP_ENABLE(PULLUP_ENABLE), .USER_IO_RELEASE(USER_IO_RELEASE));

   scl_flash_model flash (.sck(CONFIG_CLOCK_OUT), .cs_n(FLASH_SELECT_N), .mosi(FLASH_MOSI),
      .hold_n(hold_n), .miso(FLASH_DIN));

   task automatic close_out;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_lvl(ref logic s, input logic v, output int n);
      n = 0;
      while (s !== v && n < LIM) begin
         @(posedge CLOCK);
         n++;
      end
      if (n >= LIM) begin
         fails++;
         close_out();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      int n;
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h000000, a};
      HWRITE <= wr;
      HSIZE <= 3'h2;
      @(posedge CLOCK);
      wait_lvl(HREADYOUT, 1'b1, n);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      @(posedge CLOCK);
      wait_lvl(HREADYOUT, 1'b1, n);
      rd = HRDATA;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h00000000, x);
      check(x, e);
   endtask

   task automatic finish_load(input logic [2:0] vs, input logic strap, input logic [3:0] rate,
         input logic [23:0] addr, input logic [15:0] len);
      int n;
      logic [23:0] a;
      logic [31:0] w;
      logic [7:0] c;
      a = addr + 24'(4 * (len - 1));
      for (int i = 0; i < 4; i++) w = {w[23:0], (a[7:0] + 8'(i)) ^ 8'h5A};
      c = (vs == VS_FAST) ? CMD_FAST : ((vs == VS_READ) ? CMD_READ : CMD_ARRAY);
      wait_lvl(FLASH_SELECT_N, 1'b0, n);
      sel_rises = 0;
      check({31'h0, PULLUP_ENABLE}, {31'h0, !strap});
      check({29'h0, CHAIN_OE, DONE_OE, INIT_OE}, 32'h00000006);
      wr(OFS_CTRL, {24'h000000, rate, 4'h0});
      wait_lvl(CONFIG_CLOCK_OUT, 1'b1, n);
      wait_lvl(CONFIG_CLOCK_OUT, 1'b0, n);
      check(32'(n), 32'(4 * (rate + 1)));
      wait_lvl(DONE_OE, 1'b0, n);
      check(32'(sel_rises), 32'h00000000);
      check({30'h0, USER_IO_RELEASE, FLASH_SELECT_N}, 32'h00000002);
      check({30'h0, PULLUP_ENABLE, CHAIN_OUT}, {30'h0, 1'b0, w[0]});
      // The done pin crosses two synchroniser stages before the status word shows it.
      repeat (3) @(posedge CLOCK);
      rd_chk(OFS_STATUS, {14'h0, 2'b11 & {1'b1, strap}, 1'b0, MODE_SPI, 1'b0, vs, 8'h10});
      rd_chk(OFS_DATA, w);
      rd_chk(OFS_WORDS, {16'h0000, len});
      check({24'h0, flash.cmd}, {24'h0, c});
      check({8'h00, flash.addr}, {8'h00, addr});
      wr(OFS_CTRL, {23'h0, 1'b1, rate, 4'h0});
      wait_lvl(FLASH_SELECT_N, 1'b1, n);
   endtask

   task automatic run_load(input logic [2:0] vs, input logic strap, input logic [3:0] rate,
         input logic [23:0] addr, input logic [15:0] len, input logic hold, input logic abort);
      int n;
      logic [31:0] x;
      PULLUP_DISABLE_STRAP <= strap;
      VARIANT_SELECT_PINS <= hold ? 3'h4 : vs;
      init_hold <= hold;
      wr(OFS_ADDR, {8'h00, addr});
      wr(OFS_LEN, {16'h0000, len});
      wr(OFS_CTRL, {23'h0, 1'b1, rate, 4'h1});
      rd_chk(OFS_CTRL, {23'h0, 1'b1, rate, 4'h0});
      if (hold) begin
         repeat (300) @(posedge CLOCK);
         bus(1'b0, OFS_STATUS, 32'h00000000, x);
         check({26'h0, x[5:0]}, 32'h00000002);
         check({31'h0, FLASH_SELECT_N}, 32'h00000001);
         VARIANT_SELECT_PINS <= vs;
         repeat (5) @(posedge CLOCK);
         init_hold <= 1'b0;
      end
      if (abort) begin
         wait_lvl(FLASH_SELECT_N, 1'b0, n);
         repeat (200) @(posedge CLOCK);
         wr(OFS_CTRL, {23'h0, 1'b1, rate, 4'h1});
         wait_lvl(FLASH_SELECT_N, 1'b1, n);
      end
      finish_load(vs, strap, rate, addr, len);
   endtask

   task automatic run_fail(input logic [2:0] m, input logic [2:0] vs);
      logic [31:0] x;
      MODE_PINS <= m;
      VARIANT_SELECT_PINS <= vs;
      wr(OFS_CTRL, 32'h00000101);
      repeat (300) @(posedge CLOCK);
      bus(1'b0, OFS_STATUS, 32'h00000000, x);
      check({26'h0, x[5:0]}, 32'h00000020);
      check({30'h0, DONE_OE, CONFIG_CLOCK_OUT}, 32'h00000002);
      MODE_PINS <= MODE_SPI;
   endtask

   initial begin
      repeat (3) @(posedge CLOCK);
      NRST <= 1'b1;
      check({29'h0, INIT_OE, DONE_OE, FLASH_SELECT_N}, 32'h00000007);
      check({28'h0, HRESP, INIT_O, DONE_O, HREADYOUT}, 32'h00000001);
      rd_chk(OFS_CTRL, 32'h00000100);
      rd_chk(OFS_ADDR, 32'h00000000);
      rd_chk(OFS_LEN, 32'h00000004);
      wr(8'h18, 32'hFFFFFFFF);
      rd_chk(8'h18, 32'h00000000);
      finish_load(VS_FAST, 1'b0, 4'h0, 24'h000000, 16'h0004);
      run_load(VS_FAST, 1'b0, 4'h0, 24'h000100, 16'h0001, 1'b0, 1'b1);
      run_load(VS_READ, 1'b1, 4'h1, 24'h0003FD, 16'h0002, 1'b1, 1'b0);
      run_load(VS_ARRAY, 1'b0, 4'h2, 24'hABCDE0, 16'h0003, 1'b0, 1'b0);
      run_fail(3'h0, VS_FAST);
      run_fail(MODE_SPI, 3'h4);
      close_out();
   end
endmodule
